// ### shared/dssj_pkg.sv
// Package of constants and types for the doubleword shift, subtract and jump execution block.
// How it works
// - Shift-right-plus-32 shifts source right by 32 plus amount, zero filled, writes destination.
// - Doubleword ops run only in 64-bit or 32-bit kernel mode, else reserved trap.
// - Trapping subtract flags overflow when carries out of bits 62 and 63 differ.
// - Non-trapping subtract gives same result and never raises overflow.
// - Exception return has no delay slot; the next instruction is not executed.
// - With error level set, return loads error return PC and clears error level.
// - Otherwise return loads exception return PC and clears exception level.
// - Compressed mode: return PC bit 0 cleared, saved bit 0 becomes mode bit.
// - Hibernate after writeback waits for idle system bus, then stops clocks.
// - Only cold reset leaves hibernate mode.
// - Absolute jumps use delay-slot upper 36 bits, target field shifted two, one delay.
// - Absolute call link writes PC plus 8 into register 31.
// - Compressed mode: link bit 0 holds the mode bit before the jump.
// - Register call jumps to source after delay slot, links into destination register.
// - Same source and link register is undefined and not trapped.
// - Compressed mode: register jumps clear target bit 0, copy it to mode bit.
// - Compressed mode: target low two bits nonzero give address error at fetch.
// - Mode-switching call links register 31 and toggles mode bit one instruction later.
package dssj_pkg;
   localparam int XLEN = 64;
   localparam int REG_AW = 5;
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_SYSCOP = 6'h10;
   localparam logic [5:0] OP_JUMP = 6'h02;
   localparam logic [5:0] OP_ABS_CALL = 6'h03;
   localparam logic [5:0] OP_CALL_SWITCH = 6'h1D;
   localparam logic [5:0] FN_REG_JUMP = 6'h08;
   localparam logic [5:0] FN_REG_CALL = 6'h09;
   localparam logic [5:0] FN_SHR_PLUS32 = 6'h3E;
   localparam logic [5:0] FN_SUB_TRAP = 6'h2E;
   localparam logic [5:0] FN_SUB_NOTRAP = 6'h2F;
   localparam logic [5:0] FN_EXC_RETURN = 6'h18;
   localparam logic [5:0] FN_HIBERNATE = 6'h23;
   localparam int SHIFT_BASE = 32;
   localparam logic [4:0] LINK_REG = 5'h1F;
   localparam logic [63:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
   localparam int TARGET_W = 26;
   localparam int PC_KEEP_LSB = 28;
   localparam int STS_ERROR_LEVEL_BIT = 2;
   localparam int STS_EXC_LEVEL_BIT = 1;
   typedef enum logic [2:0] {
      DSSJ_EXC_NONE = 3'h0,
      DSSJ_EXC_RESERVED = 3'h1,
      DSSJ_EXC_OVERFLOW = 3'h2,
      DSSJ_EXC_COP_UNUSABLE = 3'h3,
      DSSJ_EXC_ADDR_ERROR = 3'h4
   } dssj_exc_t;
   typedef enum logic [1:0] {
      DSSJ_RUN = 2'h0,
      DSSJ_WAIT_IDLE = 2'h1,
      DSSJ_ASLEEP = 2'h2
   } dssj_pwr_t;
endpackage

// ### rtl/dssj_subtract.sv
// Doubleword subtractor with two's complement overflow detection.
`timescale 1ns/1ps
module dssj_subtract (
   input wire logic [63:0] minuend,
   input wire logic [63:0] subtrahend,
   output logic [63:0] difference,
   output logic overflow
);
   import dssj_pkg::*;
   logic [64:0] full;
   logic [63:0] low;
   // Carry out of bit 62 is the carry into bit 63 of a + ~b + 1.
   assign full = {1'b0, minuend} + {1'b0, ~subtrahend} + 65'h0_0000_0000_0000_0001;
   assign low = {1'b0, minuend[62:0]} + {1'b0, ~subtrahend[62:0]} + 64'h0000_0000_0000_0001;
   assign difference = full[63:0];
   assign overflow = low[63] ^ full[64];
endmodule // dssj_subtract

// ### rtl/dssj_exec.sv
// Execution stage for doubleword shift, subtract, exception return, hibernate and jumps.
`timescale 1ns/1ps
module dssj_exec (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic issue_valid,
   input wire logic [31:0] instr,
   input wire logic [63:0] pc,
   input wire logic [63:0] rs_value,
   input wire logic [63:0] rt_value,
   input wire logic mode64,
   input wire logic kernel_mode,
   input wire logic syscop_usable,
   input wire logic compressed_isa_enable,
   input wire logic [31:0] status_in,
   input wire logic [63:0] error_return_pc,
   input wire logic [63:0] exception_return_pc,
   input wire logic writeback_done,
   input wire logic system_address_data_bus_idle,
   output logic wb_valid,
   output logic [4:0] wb_reg,
   output logic [63:0] wb_data,
   output logic redirect_valid,
   output logic [63:0] redirect_pc,
   output logic redirect_delayed,
   output logic squash_next,
   output logic status_we,
   output logic [31:0] status_out,
   output logic isa_mode,
   output logic [2:0] exc_code,
   output logic fetch_addr_error,
   output logic clocks_stopped
);
   import dssj_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode.
   logic [5:0] opc, fn;
   logic [4:0] rd, sa;
   logic is_special, is_shr, is_subt, is_subn, is_jr, is_register_call_link;
   logic is_j, is_jal, is_call_link_switch_isa, is_exception_return, is_hib, is_dword, is_sys;
   logic dword_ok, sys_ok;
   assign opc = instr[31:26];
   assign fn = instr[5:0];
   assign rd = instr[15:11];
   assign sa = instr[10:6];
   assign is_special = issue_valid && (opc == OP_SPECIAL);
   assign is_shr = is_special && (fn == FN_SHR_PLUS32);
   assign is_subt = is_special && (fn == FN_SUB_TRAP);
   assign is_subn = is_special && (fn == FN_SUB_NOTRAP);
   assign is_jr = is_special && (fn == FN_REG_JUMP);
   assign is_register_call_link = is_special && (fn == FN_REG_CALL);
   assign is_j = issue_valid && (opc == OP_JUMP);
   assign is_jal = issue_valid && (opc == OP_ABS_CALL);
   assign is_call_link_switch_isa = issue_valid && (opc == OP_CALL_SWITCH);
   assign is_sys = issue_valid && (opc == OP_SYSCOP) && instr[25];
   assign is_exception_return = is_sys && (fn == FN_EXC_RETURN);
   assign is_hib = is_sys && (fn == FN_HIBERNATE);
   assign is_dword = is_shr || is_subt || is_subn;
   assign dword_ok = mode64 || kernel_mode;
   assign sys_ok = syscop_usable;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic.
   logic [63:0] diff, shr_res, link_addr, link_val, abs_target, reg_target;
   logic ovf, reg_target_odd;
   logic [6:0] shamt;
   dssj_subtract u_sub (
      .minuend(rs_value),
      .subtrahend(rt_value),
      .difference(diff),
      .overflow(ovf)
   );
   assign shamt = 7'(SHIFT_BASE) + {2'b00, sa};
   assign shr_res = rt_value >> shamt;
   assign link_addr = pc + LINK_OFFSET;
   // In compressed mode, bit 0 of the link carries the mode before the jump.
   assign link_val = compressed_isa_enable ? {link_addr[63:1], isa_mode} : link_addr;
   // Upper bits come from the delay slot address, which is pc plus four.
   logic [63:0] slot_addr;
   assign slot_addr = pc + 64'h0000_0000_0000_0004;
   assign abs_target = {slot_addr[63:PC_KEEP_LSB], instr[TARGET_W-1:0], 2'b00};
   assign reg_target = compressed_isa_enable ? {rs_value[63:1], 1'b0} : rs_value;
   assign reg_target_odd = compressed_isa_enable && (rs_value[1:0] != 2'b00);

   ////////////////////////////////////////////////////////////////////////////
   // Register writeback. Rd equal to rs on a register call is not trapped.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_valid <= 1'b0;
         wb_reg <= 5'h00;
         wb_data <= 64'h0000_0000_0000_0000;
      end else begin
         wb_valid <= 1'b0;
         if (is_dword && dword_ok) begin
            if (is_shr) begin
               wb_valid <= 1'b1;
               wb_data <= shr_res;
            end else if (is_subn || !ovf) begin
               wb_valid <= 1'b1;
               wb_data <= diff;
            end
            wb_reg <= rd;
         end else if (is_jal || is_call_link_switch_isa) begin
            wb_valid <= 1'b1;
            wb_reg <= LINK_REG;
            wb_data <= link_val;
         end else if (is_register_call_link) begin
            wb_valid <= 1'b1;
            wb_reg <= rd;
            wb_data <= link_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Exceptions.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         exc_code <= DSSJ_EXC_NONE;
      end else if (is_dword && !dword_ok) begin
         exc_code <= DSSJ_EXC_RESERVED;
      end else if (is_subt && ovf) begin
         exc_code <= DSSJ_EXC_OVERFLOW;
      end else if ((is_exception_return || is_hib) && !sys_ok) begin
         exc_code <= DSSJ_EXC_COP_UNUSABLE;
      end else begin
         exc_code <= DSSJ_EXC_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Redirects and status. Jumps redirect after their delay slot; return at once.
   logic ret_isa_bit, ret_go, jmp_go, isa_toggle_pend_r, reg_jump_isa_pend_r;
   logic reg_jump_isa_r, addr_err_pend_r;
   logic [63:0] ret_src;
   assign ret_go = is_exception_return && sys_ok;
   assign jmp_go = is_j || is_jal || is_call_link_switch_isa || is_jr || is_register_call_link;
   assign ret_src = status_in[STS_ERROR_LEVEL_BIT] ? error_return_pc : exception_return_pc;
   assign ret_isa_bit = ret_src[0];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         redirect_valid <= 1'b0;
         redirect_pc <= 64'h0000_0000_0000_0000;
         redirect_delayed <= 1'b0;
         squash_next <= 1'b0;
         status_we <= 1'b0;
         status_out <= 32'h0000_0000;
      end else begin
         redirect_valid <= ret_go || jmp_go;
         redirect_delayed <= jmp_go && !ret_go;
         squash_next <= ret_go;
         status_we <= ret_go;
         if (ret_go) begin
            redirect_pc <= compressed_isa_enable ? {ret_src[63:1], 1'b0} : ret_src;
            status_out <= status_in;
            if (status_in[STS_ERROR_LEVEL_BIT]) begin
               status_out[STS_ERROR_LEVEL_BIT] <= 1'b0;
            end else begin
               status_out[STS_EXC_LEVEL_BIT] <= 1'b0;
            end
         end else if (is_jr || is_register_call_link) begin
            redirect_pc <= reg_target;
         end else if (jmp_go) begin
            redirect_pc <= abs_target;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode bit. Jump effects land one instruction later, after the delay slot issues.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         isa_mode <= 1'b0;
         isa_toggle_pend_r <= 1'b0;
         reg_jump_isa_pend_r <= 1'b0;
         reg_jump_isa_r <= 1'b0;
         addr_err_pend_r <= 1'b0;
         fetch_addr_error <= 1'b0;
      end else begin
         fetch_addr_error <= 1'b0;
         if (ret_go && compressed_isa_enable) begin
            isa_mode <= ret_isa_bit;
         end else if (issue_valid && isa_toggle_pend_r) begin
            isa_mode <= ~isa_mode;
         end else if (issue_valid && reg_jump_isa_pend_r) begin
            isa_mode <= reg_jump_isa_r;
         end
         if (issue_valid && (isa_toggle_pend_r || reg_jump_isa_pend_r)) begin
            isa_toggle_pend_r <= 1'b0;
            reg_jump_isa_pend_r <= 1'b0;
            fetch_addr_error <= addr_err_pend_r;
            addr_err_pend_r <= 1'b0;
         end
         if (is_call_link_switch_isa) begin
            isa_toggle_pend_r <= 1'b1;
         end else if ((is_jr || is_register_call_link) && compressed_isa_enable) begin
            reg_jump_isa_pend_r <= 1'b1;
            reg_jump_isa_r <= rs_value[0];
            addr_err_pend_r <= reg_target_odd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Hibernate. Only the reset input leaves the sleep state.
   dssj_pwr_t pwr_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwr_r <= DSSJ_RUN;
      end else begin
         case (pwr_r)
            DSSJ_RUN: begin
               if (is_hib && sys_ok) begin
                  pwr_r <= DSSJ_WAIT_IDLE;
               end
            end
            DSSJ_WAIT_IDLE: begin
               if (writeback_done && system_address_data_bus_idle) begin
                  pwr_r <= DSSJ_ASLEEP;
               end
            end
            default: begin
               pwr_r <= DSSJ_ASLEEP;
            end
         endcase
      end
   end
   assign clocks_stopped = (pwr_r == DSSJ_ASLEEP);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sub_result_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_subn && dword_ok) |=> (wb_valid && wb_data == $past(rs_value) - $past(rt_value)))
      else $error("Subtract result wrong.");
   sub_ovf_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_subt && dword_ok && ovf) |=> (!wb_valid && exc_code == DSSJ_EXC_OVERFLOW))
      else $error("Overflowed subtract wrote destination.");
   nontrap_sub_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_subn |=> exc_code != DSSJ_EXC_OVERFLOW)
      else $error("Non-trapping subtract trapped.");
   shift_plus32_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_shr && dword_ok) |=> (wb_data[63:32] == 32'h0000_0000 && wb_valid
         && wb_data[31:0] == 32'($past(rt_value) >> (32 + $past(sa)))))
      else $error("Shift plus 32 result wrong.");
   dword_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_dword && !mode64 && !kernel_mode) |=> (exc_code == DSSJ_EXC_RESERVED && !wb_valid))
      else $error("Doubleword op allowed in user mode.");
   ret_error_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ret_go && status_in[2] && !compressed_isa_enable) |=>
         (redirect_pc == $past(error_return_pc) && !status_out[2] && squash_next))
      else $error("Error return wrong.");
   ret_exc_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ret_go && !status_in[2]) |=> (!status_out[1] && status_we && !redirect_delayed))
      else $error("Exception return wrong.");
   cop_unusable_a: assert property (@(posedge ref_clk) disable iff (rst)
      ((is_exception_return || is_hib) && !syscop_usable) |=> (!status_we && !redirect_valid))
      else $error("Privileged op acted while unusable.");
   call_link_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_jal && !compressed_isa_enable) |=> (wb_reg == 5'h1F && wb_data == $past(pc) + 64'h8))
      else $error("Call link wrong.");
   hib_stays_a: assert property (@(posedge ref_clk) disable iff (rst)
      clocks_stopped |=> clocks_stopped)
      else $error("Hibernate left without reset.");
   hib_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(clocks_stopped) |-> $past(system_address_data_bus_idle))
      else $error("Clocks stopped while bus busy.");
   switch_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_call_link_switch_isa && !ret_go) ##1 (issue_valid && !ret_go) |=> isa_mode != $past(isa_mode))
      else $error("Mode not toggled after delay slot.");
   // The check below recomputes overflow from operand signs and diff bit 63, not from the subtractor's overflow output.
   sub_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_subt && dword_ok && (rs_value[63] != rt_value[63]) && (diff[63] != rs_value[63]))
      |=> exc_code == DSSJ_EXC_OVERFLOW)
      else $error("Trapping subtract missed overflow.");
   ret_squash_a: assert property (@(posedge ref_clk) disable iff (rst)
      ret_go |=> (squash_next && redirect_valid && !redirect_delayed))
      else $error("Return did not squash next instruction.");
   ret_isa_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ret_go && compressed_isa_enable) |=> (isa_mode == $past(ret_isa_bit) && !redirect_pc[0]))
      else $error("Return mode bit wrong.");
   jump_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_j && !ret_go) |=> (redirect_valid && redirect_delayed && !wb_valid))
      else $error("Absolute jump not delayed.");
   link_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
      ((is_jal || is_call_link_switch_isa || is_register_call_link) && compressed_isa_enable)
      |=> (wb_valid && wb_data[0] == $past(isa_mode)))
      else $error("Link bit 0 does not hold mode.");
   reg_call_a: assert property (@(posedge ref_clk) disable iff (rst)
      is_register_call_link |=> (wb_valid && wb_reg == $past(rd) && redirect_delayed))
      else $error("Register call link wrong.");
   reg_target_a: assert property (@(posedge ref_clk) disable iff (rst)
      ((is_jr || is_register_call_link) && compressed_isa_enable) |=> (redirect_valid && !redirect_pc[0]))
      else $error("Register jump target bit 0 set.");
   addr_err_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_jr && compressed_isa_enable && rs_value[1]) ##1 issue_valid |=> fetch_addr_error)
      else $error("Misaligned target not flagged.");
   hib_unusable_a: assert property (@(posedge ref_clk) disable iff (rst)
      (is_hib && !syscop_usable && pwr_r == DSSJ_RUN) |=> pwr_r == DSSJ_RUN)
      else $error("Hibernate started while unusable.");
   cov_addr_err_c: cover property (@(posedge ref_clk) fetch_addr_error);
   cov_sub_ovf_c: cover property (@(posedge ref_clk) is_subt && ovf && dword_ok);
   cov_exception_return_c: cover property (@(posedge ref_clk) ret_go);
   cov_hib_c: cover property (@(posedge ref_clk) $rose(clocks_stopped));
   cov_call_link_switch_isa_c: cover property (@(posedge ref_clk) is_call_link_switch_isa);
endmodule // dssj_exec

// ### testbench/dssj_exec_tb.sv
// Self-checking bench for the doubleword shift, subtract, return, hibernate and jump stage.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module dssj_exec_tb;
   import dssj_pkg::*;
   typedef struct packed {
      logic [2:0] exc; logic wb; logic [4:0] rg; logic [63:0] dat;
      logic rv; logic [63:0] rpc; logic dly; logic sq; logic swe; logic [31:0] st;
   } dssj_note_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic issue_valid = 1'b0, mode64 = 1'b1, kernel_mode = 1'b0, syscop_usable = 1'b1;
   logic compressed_isa_enable = 1'b0, writeback_done = 1'b0, system_address_data_bus_idle = 1'b1;
   logic [31:0] instr = '0, status_in = '0, status_out;
   logic [63:0] pc = '0, rs_value = '0, rt_value = '0, error_return_pc = '0;
   logic [63:0] exception_return_pc = '0, wb_data, redirect_pc;
   logic wb_valid, redirect_valid, redirect_delayed, squash_next, status_we, isa_mode;
   logic fetch_addr_error, clocks_stopped, pend = 1'b0, exp_isa = 1'b0, fae_seen = 1'b0;
   logic [4:0] wb_reg;
   logic [2:0] exc_code;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   dssj_note_t notes[$];
   always #2 ref_clk = ~ref_clk;
   dssj_exec i_dut (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
      .pc(pc), .rs_value(rs_value), .rt_value(rt_value), .mode64(mode64),
      .kernel_mode(kernel_mode), .syscop_usable(syscop_usable),
      .compressed_isa_enable(compressed_isa_enable), .status_in(status_in),
      .error_return_pc(error_return_pc), .exception_return_pc(exception_return_pc),
      .writeback_done(writeback_done), .system_address_data_bus_idle(system_address_data_bus_idle),
      .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data), .redirect_valid(redirect_valid),
      .redirect_pc(redirect_pc), .redirect_delayed(redirect_delayed), .squash_next(squash_next),
      .status_we(status_we), .status_out(status_out), .isa_mode(isa_mode), .exc_code(exc_code),
      .fetch_addr_error(fetch_addr_error), .clocks_stopped(clocks_stopped));
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Results land exactly one cycle after the issue edge, so the note is checked then.
   always @(posedge ref_clk) begin
      dssj_note_t n;
      cyc++;
      if (fetch_addr_error === 1'b1) fae_seen = 1'b1;
      if (pend && notes.size() > 0) begin
         n = notes.pop_front();
         `CHK(exc_code, n.exc)
         `CHK(wb_valid, n.wb)
         if (n.wb) begin
            `CHK(wb_reg, n.rg)
            `CHK(wb_data, n.dat)
         end
         `CHK(redirect_valid, n.rv)
         if (n.rv) begin
            `CHK(redirect_pc, n.rpc)
            `CHK(redirect_delayed, n.dly)
         end
         `CHK(squash_next, n.sq)
         `CHK(status_we, n.swe)
         if (n.swe) `CHK(status_out, n.st)
      end
      pend = issue_valid && !rst;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic dssj_note_t nt(input logic [2:0] exc, input logic wb = 0,
         input logic [4:0] rg = 0, input logic [63:0] dat = 0, input logic rv = 0,
         input logic [63:0] rpc = 0, input logic dly = 0);
      return '{exc, wb, rg, dat, rv, rpc, dly, 1'b0, 1'b0, 32'h0};
   endfunction
   function automatic logic [31:0] spec(input logic [4:0] s, t, d, sa, input logic [5:0] fn);
      return {OP_SPECIAL, s, t, d, sa, fn};
   endfunction
   function automatic dssj_note_t sub_note(input logic [5:0] fn, input logic [63:0] a, b);
      logic [63:0] r;
      r = a - b;
      if (fn == FN_SUB_TRAP && a[63] != b[63] && r[63] != a[63]) return nt(DSSJ_EXC_OVERFLOW);
      return nt(DSSJ_EXC_NONE, 1'b1, 5'h6, r);
   endfunction
   task automatic issue(input logic [31:0] ins, input logic [63:0] p, a, b, input dssj_note_t e);
      @(posedge ref_clk);
      issue_valid <= 1'b1;
      instr <= ins;
      pc <= p;
      rs_value <= a;
      rt_value <= b;
      notes.push_back(e);
   endtask
   task automatic idle(input int k);
      repeat (k) begin
         @(posedge ref_clk);
         issue_valid <= 1'b0;
      end
   endtask
   // The delay slot is an ordinary subtract; its issue edge is where jump mode changes apply.
   task automatic slot(input logic [63:0] p);
      issue(spec(5'h1, 5'h2, 5'h6, 5'h0, FN_SUB_NOTRAP), p + 4, 64'h10, 64'h3,
         nt(DSSJ_EXC_NONE, 1'b1, 5'h6, 64'hD));
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [63:0] a, b, p, t;
      logic [31:0] st;
      logic [5:0] fn;
      int unsigned s;
      dssj_note_t n;
      s = $urandom(32'h6780);
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      idle(2);
      `CHK({wb_valid, redirect_valid, isa_mode, clocks_stopped, exc_code}, 7'h0)
      for (int i = 0; i < 8; i++) begin
         b = {$urandom, $urandom};
         s = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
         issue(spec(5'h0, 5'h3, 5'h6, 5'(s), FN_SHR_PLUS32), 64'h0, {$urandom, $urandom}, b,
            nt(DSSJ_EXC_NONE, 1'b1, 5'h6, b >> (32 + s)));
      end
      for (int i = 0; i < 14; i++) begin
         a = (i < 2) ? 64'h8000_0000_0000_0000 : (i < 4) ? 64'h7FFF_FFFF_FFFF_FFFF : {$urandom, $urandom};
         b = (i < 2) ? 64'h1 : (i < 4) ? 64'hFFFF_FFFF_FFFF_FFFF : {$urandom, $urandom};
         fn = i[0] ? FN_SUB_NOTRAP : FN_SUB_TRAP;
         issue(spec(5'h4, 5'h5, 5'h6, 5'h0, fn), 64'h0, a, b, sub_note(fn, a, b));
      end
      for (int m = 0; m < 4; m++) begin
         idle(1);
         mode64 <= m[1];
         kernel_mode <= m[0];
         issue(spec(5'h1, 5'h2, 5'h6, 5'h0, FN_SUB_NOTRAP), 64'h0, 64'h9, 64'h4, (m == 0) ?
            nt(DSSJ_EXC_RESERVED) : nt(DSSJ_EXC_NONE, 1'b1, 5'h6, 64'h5));
         issue(spec(5'h0, 5'h2, 5'h6, 5'h0, FN_SHR_PLUS32), 64'h0, 64'h0, 64'hF000_0000_0000_0000,
            (m == 0) ? nt(DSSJ_EXC_RESERVED) : nt(DSSJ_EXC_NONE, 1'b1, 5'h6, 64'hF000_0000));
      end
      p = {$urandom, $urandom} & ~64'h3;
      t = p + 4;
      a = {$urandom, $urandom} | 64'h1;
      issue({OP_JUMP, 26'h2AB_CDEF}, p, 64'h0, 64'h0, nt(DSSJ_EXC_NONE, 1'b0, 5'h0, 64'h0, 1'b1,
         {t[63:28], 26'h2AB_CDEF, 2'b00}, 1'b1));
      issue({OP_ABS_CALL, 26'h155_0F0C}, p, 64'h0, 64'h0, nt(DSSJ_EXC_NONE, 1'b1, LINK_REG,
         p + LINK_OFFSET, 1'b1, {t[63:28], 26'h155_0F0C, 2'b00}, 1'b1));
      issue(spec(5'h2, 5'h0, 5'h9, 5'h0, FN_REG_CALL), p, a, 64'h0,
         nt(DSSJ_EXC_NONE, 1'b1, 5'h9, p + 8, 1'b1, a, 1'b1));
      issue(spec(5'h2, 5'h0, 5'h0, 5'h0, FN_REG_JUMP), p, a, 64'h0,
         nt(DSSJ_EXC_NONE, 1'b0, 5'h0, 64'h0, 1'b1, a, 1'b1));
      for (int k = 0; k < 4; k++) begin
         idle(1);
         st = k[0] ? ($urandom | 32'h6) : (($urandom & ~32'h4) | 32'h2);
         a = {$urandom, $urandom} | 64'h1;
         compressed_isa_enable <= k[1];
         status_in <= st;
         error_return_pc <= k[0] ? a : ~a;
         exception_return_pc <= k[0] ? ~a : a;
         n = nt(DSSJ_EXC_NONE, 1'b0, 5'h0, 64'h0, 1'b1, k[1] ? (a & ~64'h1) : a, 1'b0);
         n.sq = 1'b1;
         n.swe = 1'b1;
         n.st = k[0] ? (st & ~32'h4) : (st & ~32'h2);
         issue({OP_SYSCOP, 1'b1, 19'h0, FN_EXC_RETURN}, p, 64'h0, 64'h0, n);
         exp_isa = k[1] ? 1'b1 : exp_isa;
         idle(2);
         `CHK(isa_mode, exp_isa)
      end
      syscop_usable <= 1'b0;
      issue({OP_SYSCOP, 1'b1, 19'h0, FN_EXC_RETURN}, p, 64'h0, 64'h0, nt(DSSJ_EXC_COP_UNUSABLE));
      issue({OP_SYSCOP, 1'b1, 19'h0, FN_HIBERNATE}, p, 64'h0, 64'h0, nt(DSSJ_EXC_COP_UNUSABLE));
      idle(1);
      writeback_done <= 1'b1;
      idle(4);
      `CHK({clocks_stopped, isa_mode}, {1'b0, exp_isa})
      writeback_done <= 1'b0;
      syscop_usable <= 1'b1;
      fae_seen = 1'b0;
      issue({OP_CALL_SWITCH, 26'h0C0_FFEE}, p, 64'h0, 64'h0, nt(DSSJ_EXC_NONE, 1'b1, LINK_REG,
         {t[63:1] + 63'h2, exp_isa}, 1'b1, {t[63:28], 26'h0C0_FFEE, 2'b00}, 1'b1));
      slot(p);
      idle(2);
      exp_isa = ~exp_isa;
      `CHK(isa_mode, exp_isa)
      issue({OP_ABS_CALL, 26'h155_0F0C}, p, 64'h0, 64'h0, nt(DSSJ_EXC_NONE, 1'b1, LINK_REG,
         {t[63:1] + 63'h2, exp_isa}, 1'b1, {t[63:28], 26'h155_0F0C, 2'b00}, 1'b1));
      slot(p);
      idle(2);
      `CHK(fae_seen, 1'b0)
      a = {$urandom, $urandom} & ~64'h3;
      issue(spec(5'h2, 5'h0, 5'h9, 5'h0, FN_REG_CALL), p, a | 64'h1, 64'h0, nt(DSSJ_EXC_NONE,
         1'b1, 5'h9, {t[63:1] + 63'h2, exp_isa}, 1'b1, a, 1'b1));
      slot(p);
      idle(2);
      `CHK(isa_mode, 1'b1)
      fae_seen = 1'b0;
      issue(spec(5'h2, 5'h0, 5'h0, 5'h0, FN_REG_JUMP), p, a | 64'h2, 64'h0,
         nt(DSSJ_EXC_NONE, 1'b0, 5'h0, 64'h0, 1'b1, a | 64'h2, 1'b1));
      slot(p);
      idle(3);
      `CHK({fae_seen, isa_mode}, 2'b10)
      system_address_data_bus_idle <= 1'b0;
      issue({OP_SYSCOP, 1'b1, 19'h0, FN_HIBERNATE}, p, 64'h0, 64'h0, nt(DSSJ_EXC_NONE));
      idle(1);
      writeback_done <= 1'b1;
      idle(4);
      `CHK(clocks_stopped, 1'b0)
      system_address_data_bus_idle <= 1'b1;
      idle(2);
      `CHK(clocks_stopped, 1'b1)
      writeback_done <= 1'b0;
      system_address_data_bus_idle <= 1'b0;
      idle(6);
      `CHK(clocks_stopped, 1'b1)
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      idle(1);
      `CHK({clocks_stopped, isa_mode}, 2'b00)
      slot(p);
      idle(3);
      `CHK(notes.size(), 0)
      tally_and_finish();
   end
endmodule // dssj_exec_tb
